// File: dv/scx_cmd_exec_props.sv
/* Assertions on the command executor's ports.
   Assumes one pclk domain and a bind from the bench. */
module scx_cmd_exec_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       spi_cs_n,
  input wire logic       hmac_start,
  input wire logic       hmac_done,
  input wire logic [7:0] ext_status
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_BUSY_SET: assert property (
    $rose(ext_status[0]) |-> ext_status == 8'h01)
    else $error("busy entry is not 01h");
  AST_HMAC_BUSY: assert property (
    hmac_start |-> ext_status == 8'h01)
    else $error("hash started while not busy");
  AST_DONE_CODE: assert property (
    $fell(ext_status[0]) |-> ext_status == 8'h80 ||
      (!ext_status[7] && ext_status[4:1] != 4'h0))
    else $error("completion code malformed");
  AST_OK_ALONE: assert property (
    ext_status[7] |-> ext_status[6:0] == 7'h00)
    else $error("success with other bits");
  AST_HOLD: assert property (
    spi_cs_n && $past(spi_cs_n, 8) && !ext_status[0] |=> $stable(ext_status))
    else $error("status moved while idle");
  AST_DONE_BOUND: assert property (
    hmac_done |-> ##[1:3] (hmac_start || !ext_status[0]))
    else $error("busy not cleared after hash");
  AST_CHECK_BOUND: assert property (
    $rose(spi_cs_n) && ext_status[0] |->
      ##[1:12] (hmac_start || !ext_status[0]))
    else $error("no check after frame end");
  AST_APB_ACK: assert property (
    psel && !penable |=> pready)
    else $error("no ready in access cycle");
  AST_ERR_RDY: assert property (
    pslverr |-> pready)
    else $error("slave error without ready");
  cover property (ext_status == 8'h80);
  cover property ($fell(ext_status[0]) && ext_status[4]);
  cover property (pslverr);
endmodule : scx_cmd_exec_props

// File: dv/scx_host_model.sv
/* Host side: serial command sender plus a stand-in hash engine.
   Assumes sends start right after a pclk edge. */
module scx_host_model (
  input  wire logic              pclk,
  output logic                   spi_sck,
  output logic                   spi_cs_n,
  output logic                   spi_mosi,
  input  wire logic              hmac_start,
  input  wire scx_pkg::scx_key_t hmac_key,
  input  wire logic [63:0]       hmac_msg,
  input  wire logic              hmac_long,
  output logic                   hmac_done,
  output scx_pkg::scx_key_t      hmac_mac
);
  timeunit 1ns;
  timeprecision 1ns;
  import scx_pkg::*;
  logic [1:0] dly = 2'h0;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    hmac_done = 1'b0;
    hmac_mac = '0;
  end
  // not a real hash: cheap, keyed and message dependent
  function automatic scx_key_t mac(scx_key_t k, logic [63:0] m);
    return {k[127:0], k[255:128]} ^ {4{m}};
  endfunction : mac
  always @(posedge pclk) begin
    hmac_done <= 1'b0;
    hmac_mac <= ~hmac_mac;
    if (hmac_start) dly <= 2'h3;
    else if (dly != 2'h0) dly <= dly - 2'h1;
    if (dly == 2'h1) begin
      hmac_done <= 1'b1;
      hmac_mac <= mac(hmac_key,
        hmac_long ? hmac_msg : {32'h0, hmac_msg[31:0]});
    end
  end
  // clock stands low between frames
  task automatic send(input logic [511:0] d, input int n);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_mosi <= d[511-i];
      repeat (4) @(posedge pclk);
      spi_sck <= 1'b1;
      repeat (4) @(posedge pclk);
      spi_sck <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
  endtask : send
endmodule : scx_host_model

// File: dv/tb.sv
/* Self-checking bench for the command executor.
   Assumes the host model and the checker are compiled first. */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scx_pkg::*;
  localparam logic [7:0] OPC = 8'hA5;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, w;
  logic        pready, pslverr, spi_sck, spi_cs_n, spi_mosi;
  logic        hmac_start, hmac_long, hmac_done, busy_q = 0;
  scx_key_t    hmac_key, hmac_mac, k1, dk;
  logic [63:0] hmac_msg;
  logic [7:0]  ext_status, stq[$];
  logic [32:0] rdq[$];
  int          err_total = 0, checked = 0, cyc = 0, seed = 32'h0FAE3622;
  always #20 pclk = ~pclk;
  scx_cmd_exec #(.NSLOT(4), .OPCODE(OPC)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .hmac_start(hmac_start), .hmac_key(hmac_key),
    .hmac_msg(hmac_msg), .hmac_long(hmac_long), .hmac_done(hmac_done),
    .hmac_mac(hmac_mac), .ext_status(ext_status));
  scx_host_model host (.pclk(pclk), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .hmac_start(hmac_start),
    .hmac_key(hmac_key), .hmac_msg(hmac_msg), .hmac_long(hmac_long),
    .hmac_done(hmac_done), .hmac_mac(hmac_mac));
  ////////////////////////////////////////////////////////////////////
  task automatic cmp_st(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t: status %h not %h", $time, g, e);
    end
  endtask : cmp_st
  task automatic cmp_rd(input logic [32:0] g, e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %0t: read %h not %h", $time, g, e);
    end
  endtask : cmp_rd
  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge keeps the next request out of this time step
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rdq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // FFh marks a frame that must leave the status alone
  task automatic frame(input logic [7:0] t, s, input logic [479:0] p,
                       input int n, input logic [7:0] e);
    if (e != 8'hFF) stq.push_back(e);
    host.send({OPC, t, s, 8'h00, p}, n);
    for (int k = 0; k < 300 && ext_status[0]; k++) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask : frame
  function automatic logic [479:0] rootp(scx_key_t k, logic [7:0] s,
                                         logic bad);
    scx_key_t m = host.mac(k, {32'h0, OPC, 8'h00, s, 8'h00});
    return {k, m[223:0] ^ {223'h0, bad}};
  endfunction : rootp
  function automatic logic [479:0] keyp(logic [7:0] t, s,
                                        logic [31:0] v, logic bad);
    return {v, host.mac(dk, {OPC, t, s, 8'h00, v}) ^ bad, 192'h0};
  endfunction : keyp
  ////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    busy_q <= ext_status[0];
    if (presetn && busy_q && !ext_status[0])
      cmp_st(ext_status, stq.size() ? stq.pop_front() : 8'hXX);
    if (psel && penable && pready && !pwrite)
      cmp_rd({pslverr, prdata}, rdq.size() ? rdq.pop_front() : 'x);
    cyc++;
    if (cyc == 70000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) k1[i*32+:32] = $random(seed);
    w = $random(seed);
    dk = host.mac(k1, {32'h0, w});
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    frame(8'h00, 8'h01, rootp(k1, 8'h01, 0), 512, 8'h80);
    frame(8'h00, 8'h01, rootp(k1, 8'h01, 0), 512, 8'h02);
    frame(8'h00, 8'h02, rootp('1, 8'h02, 0), 512, 8'h80);
    frame(8'h00, 8'h02, rootp(k1, 8'h02, 0), 512, 8'h80);
    frame(8'h00, 8'h03, rootp(k1, 8'h03, 1), 512, 8'h02);
    frame(8'h00, 8'h09, rootp(k1, 8'h09, 0), 512, 8'h02);
    frame(8'h00, 8'h03, rootp(k1, 8'h03, 0), 320, 8'h04);
    frame(8'h01, 8'h00, keyp(8'h01, 8'h00, w, 0), 320, 8'h02);
    frame(8'h02, 8'h01, keyp(8'h02, 8'h01, 0, 0), 320, 8'h08);
    frame(8'h01, 8'h01, keyp(8'h01, 8'h01, w, 1), 320, 8'h04);
    frame(8'h01, 8'h07, keyp(8'h01, 8'h07, w, 0), 320, 8'h04);
    frame(8'h01, 8'h01, keyp(8'h01, 8'h01, w, 0), 320, 8'h80);
    frame(8'h02, 8'h01, keyp(8'h02, 8'h01, 0, 0), 320, 8'h80);
    frame(8'h02, 8'h01, keyp(8'h02, 8'h01, 0, 0), 320, 8'h10);
    frame(8'h02, 8'h01, keyp(8'h02, 8'h01, 1, 0), 288, 8'h04);
    apb(1'b1, 12'h008, 32'h1);
    rd(12'h00C, {1'b0, 32'h1});
    frame(8'h00, 8'h01, '0, 7, 8'hFF);
    apb(1'b1, 12'h004, 32'h0);
    frame(8'h00, 8'h01, '0, 16, 8'hFF);
    apb(1'b1, 12'h004, 32'h1);
    rd(12'h000, {1'b0, 32'h04});
    rd(12'h010, {1'b1, 32'h0});
    frame(8'h01, 8'h01, '0, 16, 8'h04);
    rd(12'h004, {1'b0, 32'h1});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    frame(8'h02, 8'h01, keyp(8'h02, 8'h01, 1, 0), 320, 8'h08);
    if (stq.size() || rdq.size()) err_total++;
    give_verdict();
  end
endmodule : tb
bind scx_cmd_exec scx_cmd_exec_props chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .spi_cs_n(spi_cs_n), .hmac_start(hmac_start), .hmac_done(hmac_done),
  .ext_status(ext_status));

// File: hw/scx_cmd_exec.sv
/*
 * Secure counter command executor: takes authenticated commands from the
 * serial link, checks size, slot, state and signature, and posts the
 * extended status. APB slave for control and status.
 * Assumes an external HMAC-SHA-256 engine on pclk: one-cycle start with
 * key and message held, one-cycle done with the 256-bit mac.
 */
// Chosen here: the APB interface to the registers and the address map.
`include "scx_defs.svh"

////////////////////////////////////////////////////////////////////////
// Function
// - clean root key write stores key
// - root write checks low 224 mac bits
// - non-ones root key locks slot
// - all-ones root key leaves slot unlocked
// - clean command executes, status 80h
// - error leaves state, sets error bit
// - status bit 0 set while executing
// - root write size error bit 2
// - derived keys volatile, lost on reset
// - update derives key from root key
// - update signature keyed by derived key
// - update on uninit counter bit 1
// - update/inc sig, range, size bit 2
// - clean increment adds one
// - increment checks signature and count
// - increment uninit key/counter bit 3
// - increment count mismatch bit 4
// - opcode byte first, msb first
// - root key bytes 4-35, sig 36-63
// - status untouched before eight bits
module scx_cmd_exec #(
  parameter int         NSLOT  = 4,
  parameter logic [7:0] OPCODE = `SCX_OPCODE_DFLT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             hmac_start,
  output scx_pkg::scx_key_t hmac_key,
  output logic [63:0]      hmac_msg,
  output logic             hmac_long,
  input  wire logic        hmac_done,
  input  wire scx_pkg::scx_key_t hmac_mac,
  output logic [7:0]       ext_status
);
  import scx_pkg::*;

  generate
    if (NSLOT < 2 || NSLOT > 256) begin : g_chk
      $error("NSLOT must lie in 2..256");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    scx_state_e   st;
    logic         cap;
    logic         act;
    logic [9:0]   cnt;
    logic [31:0]  hdr;
    logic [511:0] sh;
    logic [7:0]   ext;
    scx_key_t     tmp;
    logic         hstart;
    scx_key_t     hkey;
    logic [63:0]  hmsg;
    logic         hlong;
    logic         en;
    logic [7:0]   sel;
    logic [31:0]  rd;
    logic         rdy;
    logic         err;
  } scx_exec_s;

  scx_exec_s q_r;
  scx_exec_s q_nxt;

  logic      f_start;
  logic      f_end;
  logic      b_stb;
  logic      b_val;
  logic      wr_root;
  logic      wr_dkey;
  logic      inc;
  scx_key_t  s_root;
  scx_key_t  s_dkey;
  logic      s_lock;
  logic      s_cini;
  logic      s_dval;
  scx_word_t s_cnt;
  scx_word_t s_cnt_rd;

  localparam logic [8:0] NS9 = 9'(NSLOT);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // 32-bit word in bytes 4..7 of a 40-byte frame
  function automatic scx_word_t f_word(input logic [511:0] sh);
    f_word = sh[287:256];
  endfunction : f_word

  function automatic logic f_in_range(input logic [7:0] idx);
    f_in_range = {1'b0, idx} < NS9;
  endfunction : f_in_range

  function automatic logic [7:0] f_bit(input int pos);
    f_bit = 8'h01 << pos;
  endfunction : f_bit

  ////////////////////////////////////////////////////////////////////
  // submodules

  scx_link_rx u_rx (
    .pclk        (pclk),
    .presetn     (presetn),
    .spi_sck     (spi_sck),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .frame_start (f_start),
    .frame_end   (f_end),
    .bit_stb     (b_stb),
    .bit_val     (b_val)
  );

  scx_slot_store #(.NSLOT(NSLOT)) u_store (
    .pclk     (pclk),
    .presetn  (presetn),
    .idx      (q_r.hdr[15:8]),
    .rd_idx   (q_r.sel),
    .wr_root  (wr_root),
    .root_in  (q_r.hkey),
    .lock_in  (q_r.hkey != '1),
    .wr_dkey  (wr_dkey),
    .dkey_in  (q_r.tmp),
    .inc      (inc),
    .root_key (s_root),
    .locked   (s_lock),
    .cinit    (s_cini),
    .dkey     (s_dkey),
    .dvalid   (s_dval),
    .count    (s_cnt),
    .count_rd (s_cnt_rd)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [7:0] ct;
    logic       sig_ok;
    logic       cnt_ok;
    logic [7:0] e;
    q_nxt        = q_r;
    q_nxt.hstart = 1'b0;
    q_nxt.rdy    = 1'b0;
    // error pulse lives only in the access cycle, like ready
    q_nxt.err    = 1'b0;
    wr_root      = 1'b0;
    wr_dkey      = 1'b0;
    inc          = 1'b0;
    ct           = q_r.hdr[23:16];
    sig_ok       = 1'b0;
    cnt_ok       = 1'b0;
    e            = 8'h00;

    // frames that start mid-execution are dropped whole
    if (f_start) begin
      q_nxt.cap = (q_r.st == S_IDLE) && q_r.en;
      q_nxt.act = 1'b0;
      q_nxt.cnt = '0;
    end

    if (b_stb && q_r.cap) begin
      q_nxt.sh = {q_r.sh[510:0], b_val};
      if (q_r.cnt < `SCX_LEN_HDR) begin
        q_nxt.hdr = {q_r.hdr[30:0], b_val};
      end
      if (q_r.cnt != `SCX_CNT_MAX) begin
        q_nxt.cnt = q_r.cnt + 10'h001;
      end
      // the opcode byte completes: only now may status move
      if (q_r.cnt == `SCX_LEN_OPC) begin
        if ({q_r.hdr[6:0], b_val} == OPCODE) begin
          q_nxt.act = 1'b1;
          q_nxt.ext = `SCX_ST_BUSY;
        end else begin
          q_nxt.cap = 1'b0;
        end
      end
    end

    if (f_end && q_r.act) begin
      q_nxt.act = 1'b0;
      q_nxt.cap = 1'b0;
      q_nxt.st  = S_CHECK;
    end

    unique case (q_r.st)
      S_IDLE: begin
      end

      S_CHECK: begin
        q_nxt.st = S_IDLE;
        unique case (ct)
          `SCX_CT_ROOT: begin
            if (q_r.cnt != `SCX_LEN_ROOT) begin
              e = f_bit(`SCX_ERR_B_BIT);
            end else if (!f_in_range(q_r.hdr[15:8]) || s_lock) begin
              e = f_bit(`SCX_ERR_A_BIT);
            end else begin
              // key from bytes 4..35 keys its own
              q_nxt.hkey   = q_r.sh[479:224];
              q_nxt.hmsg   = {32'h0, q_r.hdr};
              q_nxt.hlong  = 1'b0;
              q_nxt.hstart = 1'b1;
              q_nxt.st     = S_H1;
            end
          end
          `SCX_CT_UPD: begin
            if (q_r.cnt != `SCX_LEN_KEYED) begin
              e = f_bit(`SCX_ERR_B_BIT);
            end else if (!f_in_range(q_r.hdr[15:8])) begin
              e = f_bit(`SCX_ERR_B_BIT);
            end else if (!s_cini) begin
              e = f_bit(`SCX_ERR_A_BIT);
            end else begin
              q_nxt.hkey   = s_root;
              q_nxt.hmsg   = {32'h0, f_word(q_r.sh)};
              q_nxt.hlong  = 1'b0;
              q_nxt.hstart = 1'b1;
              q_nxt.st     = S_H1;
            end
          end
          `SCX_CT_INC: begin
            if (q_r.cnt != `SCX_LEN_KEYED) begin
              e = f_bit(`SCX_ERR_B_BIT);
            end else if (!f_in_range(q_r.hdr[15:8])) begin
              e = f_bit(`SCX_ERR_B_BIT);
            end else if (!s_dval || !s_cini) begin
              e = f_bit(`SCX_ERR_C_BIT);
            end else begin
              q_nxt.hkey   = s_dkey;
              q_nxt.hmsg   = {q_r.hdr, f_word(q_r.sh)};
              q_nxt.hlong  = 1'b1;
              q_nxt.hstart = 1'b1;
              q_nxt.st     = S_H1;
            end
          end
          default: begin
            // unknown command type counts as a size-class error
            e = f_bit(`SCX_ERR_B_BIT);
          end
        endcase
        if (q_nxt.st == S_IDLE) begin
          q_nxt.ext = e;
        end
      end

      S_H1: begin
        if (hmac_done) begin
          q_nxt.st = S_IDLE;
          unique case (ct)
            `SCX_CT_ROOT: begin
              sig_ok = hmac_mac[223:0] == q_r.sh[223:0];
              if (sig_ok) begin
                wr_root   = 1'b1;
                q_nxt.ext = `SCX_ST_OK;
              end else begin
                q_nxt.ext = f_bit(`SCX_ERR_A_BIT);
              end
            end
            `SCX_CT_UPD: begin
              // derived key is kept aside until it proves itself
              q_nxt.tmp    = hmac_mac;
              q_nxt.hkey   = hmac_mac;
              q_nxt.hmsg   = {q_r.hdr, f_word(q_r.sh)};
              q_nxt.hlong  = 1'b1;
              q_nxt.hstart = 1'b1;
              q_nxt.st     = S_H2;
            end
            default: begin
              sig_ok = hmac_mac == q_r.sh[255:0];
              cnt_ok = f_word(q_r.sh) == s_cnt;
              if (!sig_ok) begin
                e = e | f_bit(`SCX_ERR_B_BIT);
              end
              if (!cnt_ok) begin
                e = e | f_bit(`SCX_ERR_D_BIT);
              end
              if (sig_ok && cnt_ok) begin
                inc       = 1'b1;
                q_nxt.ext = `SCX_ST_OK;
              end else begin
                q_nxt.ext = e;
              end
            end
          endcase
        end
      end

      S_H2: begin
        if (hmac_done) begin
          q_nxt.st = S_IDLE;
          if (hmac_mac == q_r.sh[255:0]) begin
            wr_dkey   = 1'b1;
            q_nxt.ext = `SCX_ST_OK;
          end else begin
            q_nxt.ext = f_bit(`SCX_ERR_B_BIT);
          end
        end
      end
    endcase

    // apb: answer registered in setup, shown in the single access cycle
    if (psel && !penable) begin
      q_nxt.rdy = 1'b1;
      q_nxt.err = 1'b0;
      unique case (paddr)
        `SCX_OFS_STATUS: q_nxt.rd = {24'h0, q_r.ext};
        `SCX_OFS_CTRL:   q_nxt.rd = {31'h0, q_r.en};
        `SCX_OFS_SLOT:   q_nxt.rd = {24'h0, q_r.sel};
        `SCX_OFS_COUNT: begin
          q_nxt.rd = f_in_range(q_r.sel) ? s_cnt_rd : 32'h0;
        end
        default: begin
          q_nxt.rd  = 32'h0;
          q_nxt.err = 1'b1;
        end
      endcase
    end

    if (psel && penable && q_r.rdy && pwrite && !q_r.err) begin
      if (paddr == `SCX_OFS_CTRL) begin
        q_nxt.en = pwdata[`SCX_CTRL_EN_BIT];
      end
      if (paddr == `SCX_OFS_SLOT) begin
        q_nxt.sel = pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r     <= '0;
      q_r.st  <= S_IDLE;
      q_r.ext <= `SCX_ST_RST;
      q_r.en  <= `SCX_CTRL_RST;
      q_r.sel <= `SCX_SLOT_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata     = q_r.rd;
  assign pready     = q_r.rdy;
  assign pslverr    = q_r.err;
  assign hmac_start = q_r.hstart;
  assign hmac_key   = q_r.hkey;
  assign hmac_msg   = q_r.hmsg;
  assign hmac_long  = q_r.hlong;
  assign ext_status = q_r.ext;
endmodule : scx_cmd_exec

// File: hw/scx_link_rx.sv
/*
 * Serial link receiver: synchronises clock, select and data pins and
 * reports frame edges and sampled bits. Assumes link slower than pclk/4.
 */
module scx_link_rx (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic spi_sck,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  output logic      frame_start,
  output logic      frame_end,
  output logic      bit_stb,
  output logic      bit_val
);
  import scx_pkg::*;

  typedef struct packed {
    logic [2:0] sck;
    logic [2:0] csn;
    logic [1:0] mo;
  } scx_rx_s;

  scx_rx_s q_r;
  scx_rx_s q_nxt;

  always_comb begin
    q_nxt     = q_r;
    q_nxt.sck = {q_r.sck[1:0], spi_sck};
    q_nxt.csn = {q_r.csn[1:0], spi_cs_n};
    q_nxt.mo  = {q_r.mo[0], spi_mosi};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '{sck: 3'h0, csn: 3'h7, mo: 2'h0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // bits are taken msb first on each rising link clock edge
  assign frame_start = ~q_r.csn[1] & q_r.csn[2];
  assign frame_end   = q_r.csn[1] & ~q_r.csn[2];
  assign bit_stb     = q_r.sck[1] & ~q_r.sck[2] & ~q_r.csn[1];
  assign bit_val     = q_r.mo[1];
endmodule : scx_link_rx

// File: hw/scx_slot_store.sv
/*
 * Per-slot storage: root keys, lock and init flags, derived keys and
 * monotonic counters. Assumes the caller range-checks the slot index.
 */
module scx_slot_store #(
  parameter int NSLOT = 4
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] idx,
  input  wire logic [7:0] rd_idx,
  input  wire logic       wr_root,
  input  wire scx_pkg::scx_key_t root_in,
  input  wire logic       lock_in,
  input  wire logic       wr_dkey,
  input  wire scx_pkg::scx_key_t dkey_in,
  input  wire logic       inc,
  output scx_pkg::scx_key_t  root_key,
  output logic               locked,
  output logic               cinit,
  output scx_pkg::scx_key_t  dkey,
  output logic               dvalid,
  output scx_pkg::scx_word_t count,
  output scx_pkg::scx_word_t count_rd
);
  import scx_pkg::*;

  localparam int IW = $clog2(NSLOT);

  typedef struct packed {
    logic [NSLOT-1:0][255:0] root;
    logic [NSLOT-1:0][255:0] dk;
    logic [NSLOT-1:0][31:0]  cnt;
    logic [NSLOT-1:0]        lock;
    logic [NSLOT-1:0]        cini;
    logic [NSLOT-1:0]        dval;
  } scx_store_s;

  scx_store_s q_r;
  scx_store_s q_nxt;
  logic [IW-1:0] i;

  assign i        = idx[IW-1:0];
  assign root_key = q_r.root[i];
  assign locked   = q_r.lock[i];
  assign cinit    = q_r.cini[i];
  assign dkey     = q_r.dk[i];
  assign dvalid   = q_r.dval[i];
  assign count    = q_r.cnt[i];
  assign count_rd = q_r.cnt[rd_idx[IW-1:0]];

  always_comb begin
    q_nxt = q_r;
    if (wr_root) begin
      q_nxt.root[i] = root_in;
      q_nxt.lock[i] = q_r.lock[i] | lock_in;
      q_nxt.cini[i] = 1'b1;
    end
    if (wr_dkey) begin
      q_nxt.dk[i]   = dkey_in;
      q_nxt.dval[i] = 1'b1;
    end
    if (inc) begin
      q_nxt.cnt[i] = q_r.cnt[i] + 32'h1;
    end
  end

  // reset stands for power loss: root and derived keys, lock and init flags and counters all vanish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule : scx_slot_store

// File: shared/scx_defs.svh
/*
 * Offsets, field positions, reset values and frame lengths of the secure
 * counter command block. Assumes inclusion after the package.
 */
`ifndef SCX_DEFS_SVH
`define SCX_DEFS_SVH

`define SCX_OFS_STATUS  12'h000
`define SCX_OFS_CTRL    12'h004
`define SCX_OFS_SLOT    12'h008
`define SCX_OFS_COUNT   12'h00C

`define SCX_CTRL_EN_BIT 0
`define SCX_CTRL_RST    1'h1
`define SCX_SLOT_RST    8'h00

`define SCX_ST_RST      8'h00
`define SCX_ST_OK       8'h80
`define SCX_ST_BUSY     8'h01
`define SCX_ERR_A_BIT   1
`define SCX_ERR_B_BIT   2
`define SCX_ERR_C_BIT   3
`define SCX_ERR_D_BIT   4

`define SCX_CT_ROOT     8'h00
`define SCX_CT_UPD      8'h01
`define SCX_CT_INC      8'h02

`define SCX_LEN_ROOT    10'h200
`define SCX_LEN_KEYED   10'h140
`define SCX_LEN_HDR     10'h020
`define SCX_LEN_OPC     10'h007
`define SCX_CNT_MAX     10'h3FF
`define SCX_OPCODE_DFLT 8'hA5

`endif

// File: shared/scx_pkg.sv
/*
 * Types shared by the secure counter command block.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package scx_pkg;
  typedef logic [255:0] scx_key_t;
  typedef logic [31:0]  scx_word_t;
  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_H1, S_H2
  } scx_state_e;
endpackage : scx_pkg
